// file: shared/ttc_pkg.sv
// Constants, register map and carrier types of the turntable I/O block
// Function
// - Mode select high means manual, else auto
// - Mode indicator shows manual operation
// - Start input launches the selected step number
// - Pause input low holds motion interrupted
// - Home input high runs homing, low stops
// - Servo follows enable input; ready flags it
// - Alarm clear resets alarm and remaining travel
// - Teach input enters teach mode; indicator shows
// - Teach write held over 20 ms stores position
// - Write done pulses 30 ms, low outside teach
// - Step select picks inching, else continuous jog
// - Plus input jogs positive, release decelerates
// - Minus input jogs negative, release decelerates
// - Direct moves, level or edge, lowest wins
// - Arrived step number shown after positioning
// - Moving output high while motor operates
// - In-position when within completed width
// - Homing done flag after homing completes
// - Parameter zone flag between configured bounds
// - Step zone flag inside active step range
// - Emergency ok high unless stop circuit open
// - Load flag after torque over threshold long
package ttc_pkg;

  // Clock rate and documented times
  localparam int CLK_HZ        = 10_000_000;
  localparam int TEACH_HOLD_MS = 20;
  localparam int WDONE_MS      = 30;
  localparam int TEACH_HOLD_CYC = (TEACH_HOLD_MS * (CLK_HZ / 1000));
  localparam int WDONE_CYC      = (WDONE_MS * (CLK_HZ / 1000));

  // Field widths
  localparam int POS_W  = 16;
  localparam int TRQ_W  = 16;
  localparam int STEP_W = 8;
  localparam int DIR_N  = 7;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_INPOS_W   = 8'h04;
  localparam logic [7:0] OFS_ZONE_LO   = 8'h08;
  localparam logic [7:0] OFS_ZONE_HI   = 8'h0c;
  localparam logic [7:0] OFS_JUDGE_LO  = 8'h10;
  localparam logic [7:0] OFS_JUDGE_HI  = 8'h14;
  localparam logic [7:0] OFS_TRQ_THR   = 8'h18;
  localparam logic [7:0] OFS_TRQ_TIME  = 8'h1c;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  localparam logic [7:0] OFS_POSITION  = 8'h24;

  // Field positions
  localparam int CTRL_EDGE_BIT = 0;

  // Reset values
  localparam logic             RST_EDGE_MODE = 1'b0;
  localparam logic [POS_W-1:0] RST_INPOS_W   = 16'h0004;
  localparam logic [POS_W-1:0] RST_ZONE_LO   = 16'h0000;
  localparam logic [POS_W-1:0] RST_ZONE_HI   = 16'hffff;
  localparam logic [POS_W-1:0] RST_JUDGE_LO  = 16'h0000;
  localparam logic [POS_W-1:0] RST_JUDGE_HI  = 16'hffff;
  localparam logic [TRQ_W-1:0] RST_TRQ_THR   = 16'hffff;
  localparam logic [15:0]      RST_TRQ_TIME  = 16'h0064;

  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Discrete inputs as they arrive on the connector
  typedef struct packed {
    logic              mode_select;
    logic              program_start_input;
    logic [STEP_W-1:0] position_select_inputs;
    logic              pause_n;
    logic              home_input;
    logic              servo_enable_input;
    logic              alarm_clear_input;
    logic              teach_mode_input;
    logic              teach_write_input;
    logic              manual_step_select;
    logic              manual_move_plus;
    logic              manual_move_minus;
    logic [DIR_N-1:0]  direct_move_inputs;
    logic              estop_closed;
  } ttc_pin_in_t;

  // Discrete status outputs
  typedef struct packed {
    logic              operation_mode_indicator;
    logic [STEP_W-1:0] arrived_position_outputs;
    logic              moving;
    logic              in_position_flag;
    logic              servo_ready_flag;
    logic              alarm_flag;
    logic              teach_mode_indicator;
    logic              teach_write_done;
    logic              homing_done_flag;
    logic              param_zone_flag;
    logic              step_zone_flag;
    logic              emergency_stop_ok;
    logic              load_judge_flag;
    logic              torque_level_flag;
  } ttc_pin_out_t;

  // Commands to the motion core
  typedef struct packed {
    logic              start_req;
    logic [STEP_W-1:0] start_step;
    logic              manual_mode;
    logic              servo_on;
    logic              pause_hold;
    logic              home_run;
    logic              clear_alarm;
    logic              discard_remaining;
    logic              teach_mode;
    logic              jog_plus;
    logic              jog_minus;
    logic              inching;
    logic              teach_store;
    logic [STEP_W-1:0] teach_index;
  } ttc_cmd_t;

  // State returned by the motion core
  typedef struct packed {
    logic [POS_W-1:0] position;
    logic [POS_W-1:0] target;
    logic             moving;
    logic             home_done;
    logic             alarm_event;
    logic [TRQ_W-1:0] torque;
    logic [POS_W-1:0] step_lo;
    logic [POS_W-1:0] step_hi;
  } ttc_core_t;

endpackage

// file: rtl/ttc_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module ttc_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Stage chain; only the second stage looks at the first
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit, the output moves only when two later stages agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
  end

endmodule // ttc_sync

// file: rtl/ttc_io.sv
// Discrete I/O command and status logic with an AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module ttc_io
  import ttc_pkg::*;
#(
  parameter int TEACH_HOLD = TEACH_HOLD_CYC,
  parameter int WDONE      = WDONE_CYC
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // Connector side
  input  wire ttc_pin_in_t  pin_in,
  output ttc_pin_out_t      pin_out,
  // Motion core side
  input  wire ttc_core_t    core,
  output ttc_cmd_t          cmd
);

  localparam int HOLD_W = $clog2(TEACH_HOLD + 2);
  localparam int DONE_W = $clog2(WDONE + 1);
  localparam logic [HOLD_W-1:0] HOLD_N = HOLD_W'(TEACH_HOLD);
  localparam logic [DONE_W-1:0] DONE_N = DONE_W'(WDONE);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [$bits(ttc_pin_in_t)-1:0] pin_raw;
  logic [$bits(ttc_pin_in_t)-1:0] pin_sync;
  ttc_pin_in_t                    pin;

  assign pin_raw = pin_in;
  assign pin     = ttc_pin_in_t'(pin_sync);

  ttc_sync
  #(
    .W ($bits(ttc_pin_in_t))
  )
  u_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .d    (pin_raw),
    .q    (pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register file over AHB-Lite

  logic             edge_mode_q;
  logic [POS_W-1:0] inpos_w_q;
  logic [POS_W-1:0] zone_lo_q;
  logic [POS_W-1:0] zone_hi_q;
  logic [POS_W-1:0] judge_lo_q;
  logic [POS_W-1:0] judge_hi_q;
  logic [TRQ_W-1:0] trq_thr_q;
  logic [15:0]      trq_time_q;
  logic             wr_pend_q;
  logic [7:0]       wr_addr_q;
  logic             addr_ok;
  logic [31:0]      rd_d;
  logic [31:0]      status_w;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Address phase of a word write is remembered for its data phase
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_q <= addr_ok && hwrite && (hsize == HSIZE_WORD)
                   && (haddr[31:8] == 24'h000000);
      wr_addr_q <= haddr[7:0];
    end
  end

  // Data phase write; unmapped or read-only offsets are ignored
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      edge_mode_q <= RST_EDGE_MODE;
      inpos_w_q   <= RST_INPOS_W;
      zone_lo_q   <= RST_ZONE_LO;
      zone_hi_q   <= RST_ZONE_HI;
      judge_lo_q  <= RST_JUDGE_LO;
      judge_hi_q  <= RST_JUDGE_HI;
      trq_thr_q   <= RST_TRQ_THR;
      trq_time_q  <= RST_TRQ_TIME;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == OFS_CTRL)
        edge_mode_q <= hwdata[CTRL_EDGE_BIT];
      else if (wr_addr_q == OFS_INPOS_W)
        inpos_w_q <= hwdata[POS_W-1:0];
      else if (wr_addr_q == OFS_ZONE_LO)
        zone_lo_q <= hwdata[POS_W-1:0];
      else if (wr_addr_q == OFS_ZONE_HI)
        zone_hi_q <= hwdata[POS_W-1:0];
      else if (wr_addr_q == OFS_JUDGE_LO)
        judge_lo_q <= hwdata[POS_W-1:0];
      else if (wr_addr_q == OFS_JUDGE_HI)
        judge_hi_q <= hwdata[POS_W-1:0];
      else if (wr_addr_q == OFS_TRQ_THR)
        trq_thr_q <= hwdata[TRQ_W-1:0];
      else if (wr_addr_q == OFS_TRQ_TIME)
        trq_time_q <= hwdata[15:0];
    end
  end

  // Read mux; sampled in the address phase so data stands in the data phase
  always_comb
  begin
    rd_d = 32'h00000000;
    if (haddr[31:8] != 24'h000000)
      rd_d = 32'h00000000;
    else if (haddr[7:0] == OFS_CTRL)
      rd_d = {31'h00000000, edge_mode_q};
    else if (haddr[7:0] == OFS_INPOS_W)
      rd_d = {16'h0000, inpos_w_q};
    else if (haddr[7:0] == OFS_ZONE_LO)
      rd_d = {16'h0000, zone_lo_q};
    else if (haddr[7:0] == OFS_ZONE_HI)
      rd_d = {16'h0000, zone_hi_q};
    else if (haddr[7:0] == OFS_JUDGE_LO)
      rd_d = {16'h0000, judge_lo_q};
    else if (haddr[7:0] == OFS_JUDGE_HI)
      rd_d = {16'h0000, judge_hi_q};
    else if (haddr[7:0] == OFS_TRQ_THR)
      rd_d = {16'h0000, trq_thr_q};
    else if (haddr[7:0] == OFS_TRQ_TIME)
      rd_d = {16'h0000, trq_time_q};
    else if (haddr[7:0] == OFS_STATUS)
      rd_d = status_w;
    else if (haddr[7:0] == OFS_POSITION)
      rd_d = {16'h0000, core.position};
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      hrdata <= 32'h00000000;
    else if (addr_ok && !hwrite)
      hrdata <= rd_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Modes, servo, pause, home, alarm

  logic manual_w;
  logic teach_w;
  logic alarm_q;
  logic clr_prev_q;
  logic clr_rise;
  logic ready_w;

  assign manual_w = pin.mode_select;
  assign teach_w  = pin.teach_mode_input;
  assign clr_rise = pin.alarm_clear_input && !clr_prev_q;
  // Motion commands need servo on and no alarm
  assign ready_w  = pin.servo_enable_input && !alarm_q;

  // Alarm latch; a new event in the clearing cycle keeps the alarm set
  always_ff @(posedge clk)
  begin
    if (!nrst)
      alarm_q <= 1'b0;
    else if (core.alarm_event)
      alarm_q <= 1'b1;
    else if (pin.alarm_clear_input)
      alarm_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      clr_prev_q <= 1'b0;
    else
      clr_prev_q <= pin.alarm_clear_input;
  end

  //////////////////////////////////////////////////////////////////////////
  // Start selection: program start and direct moves

  logic              program_start_input_prev_q;
  logic [DIR_N-1:0]  dir_prev_q;
  logic [DIR_N-1:0]  dir_req;
  logic              dir_hit;
  logic [STEP_W-1:0] dir_step;
  logic              start_ok;
  logic              start_d;
  logic [STEP_W-1:0] step_d;

  // Only in auto, idle and not paused; in level mode a held direct input restarts motion once idle
  assign start_ok = !manual_w && !teach_w && ready_w && !core.moving
                    && pin.pause_n;
  // Level or edge triggering per control bit
  assign dir_req  = edge_mode_q ? (pin.direct_move_inputs & ~dir_prev_q)
                                : pin.direct_move_inputs;

  // Lowest-numbered request wins
  always_comb
  begin
    dir_hit  = 1'b0;
    dir_step = '0;
    for (int i = DIR_N - 1; i >= 0; i--)
    begin
      if (dir_req[i])
      begin
        dir_hit  = 1'b1;
        dir_step = STEP_W'(i);
      end
    end
  end

  // Program start on rising edge uses the selected step number
  always_comb
  begin
    start_d = 1'b0;
    step_d  = pin.position_select_inputs;
    if (start_ok && pin.program_start_input && !program_start_input_prev_q)
      start_d = 1'b1;
    else if (start_ok && dir_hit)
    begin
      start_d = 1'b1;
      step_d  = dir_step;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      program_start_input_prev_q <= 1'b0;
      dir_prev_q  <= '0;
    end
    else
    begin
      program_start_input_prev_q <= pin.program_start_input;
      dir_prev_q  <= pin.direct_move_inputs;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Arrival tracking

  logic [STEP_W-1:0] active_step_q;
  logic [STEP_W-1:0] arrived_q;
  logic              moving_prev_q;

  // Step in flight, then reported when motion ends
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      active_step_q <= '0;
      arrived_q     <= '0;
      moving_prev_q <= 1'b0;
    end
    else
    begin
      moving_prev_q <= core.moving;
      if (start_d)
        active_step_q <= step_d;
      if (moving_prev_q && !core.moving)
        arrived_q <= active_step_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Teach write hold and done pulse

  logic [HOLD_W-1:0] hold_cnt_q;
  logic              store_d;
  logic [DONE_W-1:0] done_cnt_q;

  assign store_d = teach_w && pin.teach_write_input && (hold_cnt_q == HOLD_N);

  // Counts held cycles; fires once per hold, after more than the hold time
  always_ff @(posedge clk)
  begin
    if (!nrst)
      hold_cnt_q <= '0;
    else if (!(teach_w && pin.teach_write_input))
      hold_cnt_q <= '0;
    else if (hold_cnt_q <= HOLD_N)
      hold_cnt_q <= hold_cnt_q + 1'b1;
  end

  // Done pulse; leaving teach mode forces it low at once
  always_ff @(posedge clk)
  begin
    if (!nrst)
      done_cnt_q <= '0;
    else if (!teach_w)
      done_cnt_q <= '0;
    else if (store_d)
      done_cnt_q <= DONE_N;
    else if (done_cnt_q != '0)
      done_cnt_q <= done_cnt_q - 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Position windows and torque judgment

  logic [POS_W-1:0] dist_w;
  logic             inpos_w;
  logic             zone_w;
  logic             szone_w;
  logic             trq_over;
  logic [15:0]      trq_cnt_q;
  logic             load_w;

  assign dist_w  = (core.position >= core.target)
                   ? (core.position - core.target)
                   : (core.target - core.position);
  assign inpos_w = (dist_w <= inpos_w_q);
  assign zone_w  = (core.position >= zone_lo_q)
                   && (core.position <= zone_hi_q);
  assign szone_w = (core.position >= core.step_lo)
                   && (core.position <= core.step_hi);
  // Torque level compares only while moving
  assign trq_over = core.moving && (core.torque > trq_thr_q);
  assign load_w   = (trq_cnt_q >= trq_time_q);

  // Over-threshold time inside the judgment range, saturating
  always_ff @(posedge clk)
  begin
    if (!nrst)
      trq_cnt_q <= '0;
    else if (!(trq_over && core.position >= judge_lo_q
               && core.position <= judge_hi_q))
      trq_cnt_q <= '0;
    else if (trq_cnt_q != 16'hffff)
      trq_cnt_q <= trq_cnt_q + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Commands to the motion core

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cmd <= '0;
    else
    begin
      cmd.start_req         <= start_d;
      cmd.start_step        <= step_d;
      cmd.manual_mode       <= manual_w;
      cmd.servo_on          <= pin.servo_enable_input;
      cmd.pause_hold        <= !pin.pause_n;
      cmd.home_run          <= pin.home_input && ready_w;
      cmd.clear_alarm       <= clr_rise;
      cmd.discard_remaining <= clr_rise;
      cmd.teach_mode        <= teach_w;
      cmd.jog_plus          <= teach_w && ready_w
                               && pin.manual_move_plus
                               && !pin.manual_move_minus;
      cmd.jog_minus         <= teach_w && ready_w
                               && pin.manual_move_minus
                               && !pin.manual_move_plus;
      cmd.inching           <= teach_w && pin.manual_step_select;
      cmd.teach_store       <= store_d;
      cmd.teach_index       <= pin.position_select_inputs;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status pins and status word

  always_ff @(posedge clk)
  begin
    if (!nrst)
      pin_out <= '0;
    else
    begin
      pin_out.operation_mode_indicator <= manual_w;
      pin_out.arrived_position_outputs <= arrived_q;
      pin_out.moving                   <= core.moving;
      pin_out.in_position_flag         <= inpos_w;
      pin_out.servo_ready_flag         <= pin.servo_enable_input;
      pin_out.alarm_flag               <= alarm_q;
      pin_out.teach_mode_indicator     <= teach_w;
      pin_out.teach_write_done         <= (done_cnt_q != '0);
      pin_out.homing_done_flag         <= core.home_done;
      pin_out.param_zone_flag          <= zone_w;
      pin_out.step_zone_flag           <= szone_w;
      pin_out.emergency_stop_ok        <= pin.estop_closed;
      pin_out.load_judge_flag          <= load_w;
      pin_out.torque_level_flag        <= trq_over;
    end
  end

  // Software view of the pins as they are driven
  assign status_w = {11'h000, pin_out};

endmodule // ttc_io

// file: verif/ttc_core_model.sv
// Motion core stand-in that answers start and homing commands
`timescale 1ns/100ps
module ttc_core_model
  import ttc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire ttc_cmd_t cmd,
  input  wire logic     alarm_in,
  output ttc_core_t     core
);
  logic [3:0] left_q;

  //////////////////////////////////////////////////////////////////
  // A start runs eight cycles, then lands on the target; a new
  // start during a move is ignored, as the real core would
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      left_q <= 4'h0;
      core   <= '0;
    end
    else
    begin
      core.step_hi     <= 16'hffff;
      core.alarm_event <= alarm_in;
      core.home_done   <= cmd.home_run;
      if (cmd.start_req && left_q == 4'h0)
      begin
        left_q      <= 4'h8;
        core.moving <= 1'b1;
        core.target <= {8'h00, cmd.start_step};
      end
      else if (left_q != 4'h0)
      begin
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1)
        begin
          core.moving   <= 1'b0;
          core.position <= core.target;
        end
      end
    end
  end
endmodule // ttc_core_model

// file: verif/ttc_io_properties.sv
// Concurrent checks on the pin behaviour of the turntable I/O block
`timescale 1ns/100ps
module ttc_io_props
  import ttc_pkg::*;
#(
  parameter int WDONE = WDONE_CYC
)
(
  input wire logic         clk,
  input wire logic         nrst,
  input wire ttc_pin_in_t  pin_in,
  input wire ttc_pin_out_t pin_out,
  input wire ttc_cmd_t     cmd
);
  int unsigned hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  //////////////////////////////////////////////////////////////////
  // Cycles the write-done pulse has stood so far
  always_ff @(posedge clk)
  begin
    if (!nrst || !pin_out.teach_write_done)
      hi_q <= 0;
    else
      hi_q <= hi_q + 1;
  end

  // Eight samples cover the synchroniser latency
  sequence s_store;
    cmd.teach_store;
  endsequence
  sequence s_teach_off;
    (!pin_in.teach_mode_input)[*8];
  endsequence

  //////////////////////////////////////////////////////////////////
  mode_manual_a: assert property (
    pin_in.mode_select[*8] |->
    pin_out.operation_mode_indicator && cmd.manual_mode)
    else $error("manual mode not shown");
  mode_auto_a: assert property (
    (!pin_in.mode_select)[*8] |-> !pin_out.operation_mode_indicator)
    else $error("auto mode not shown");
  servo_ready_a: assert property (
    pin_in.servo_enable_input[*8] |->
    pin_out.servo_ready_flag && cmd.servo_on)
    else $error("servo not ready");
  servo_drop_a: assert property (
    (!pin_in.servo_enable_input)[*8] |-> !pin_out.servo_ready_flag)
    else $error("servo ready while off");
  pause_hold_a: assert property (
    (!pin_in.pause_n)[*8] |-> cmd.pause_hold)
    else $error("pause not held");
  home_stop_a: assert property (
    (!pin_in.home_input)[*8] |-> !cmd.home_run)
    else $error("homing runs while off");
  estop_open_a: assert property (
    (!pin_in.estop_closed)[*8] |-> !pin_out.emergency_stop_ok)
    else $error("stop circuit open not shown");
  teach_ind_a: assert property (
    pin_in.teach_mode_input[*8] |->
    pin_out.teach_mode_indicator && cmd.teach_mode)
    else $error("teach mode not shown");
  wdone_off_a: assert property (
    s_teach_off |-> !pin_out.teach_write_done)
    else $error("write done outside teach");
  store_done_a: assert property (
    s_store |=> pin_out.teach_write_done)
    else $error("no done after store");
  wdone_len_a: assert property (
    pin_out.teach_write_done |-> hi_q < WDONE)
    else $error("write done too long");
endmodule // ttc_io_props

bind ttc_io ttc_io_props #(.WDONE(WDONE)) u_props (
  .clk, .nrst, .pin_in, .pin_out, .cmd);

// file: verif/test_turntable_controller_io.sv
// Self-checking bench for the turntable discrete I/O block
`timescale 1ns/100ps
module test_turntable_controller_io
  import ttc_pkg::*;
;
  localparam int WD = 30;
  logic         clk      = 1'b0;
  logic         nrst     = 1'b0;
  logic [1:0]   htrans   = 2'b00;
  logic [31:0]  haddr    = '0;
  logic         hwrite   = 1'b0;
  logic [31:0]  hwdata   = '0;
  logic         hreadyout;
  logic [31:0]  hrdata;
  logic         alarm_in = 1'b0;
  ttc_pin_in_t  pin      = '0;
  ttc_pin_out_t po;
  ttc_core_t    core;
  ttc_cmd_t     cmd;
  int           failures = 0;
  int           checked  = 0;
  logic [31:0]  rd;

  // Free-running clock, 100 ns period
  always #50 clk = ~clk;

  ttc_io #(.TEACH_HOLD(20), .WDONE(WD)) uut (.clk, .nrst,
    .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(),
    .pin_in(pin), .pin_out(po), .core, .cmd);
  ttc_core_model u_core (.clk, .nrst, .cmd, .alarm_in, .core);

  //////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // A used-up wait bound ends the run
  task automatic lim(input int n, input int m);
    if (n >= m)
    begin
      failures++;
      stop_test();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_rdy();
    int n;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        return;
    end
    lim(n, 20);
  endtask

  // Single word transfer; address phase held until ready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wait_start();
    int n;
    for (n = 0; n < 50 && cmd.start_req !== 1'b1; n++)
      @(posedge clk);
    lim(n, 50);
  endtask

  // Motion must show, then end; the last flags settle after
  task automatic settle();
    int n;
    for (n = 0; n < 30 && po.moving !== 1'b1; n++)
      @(posedge clk);
    lim(n, 30);
    for (n = 0; n < 40 && po.moving !== 1'b0; n++)
      @(posedge clk);
    lim(n, 40);
    cyc(4);
  endtask

  //////////////////////////////////////////////////////////////////
  task automatic t_levels();
    pin.mode_select        <= 1'b1;
    pin.servo_enable_input <= 1'b1;
    pin.pause_n            <= 1'b0;
    pin.estop_closed       <= 1'b0;
    pin.home_input         <= 1'b1;
    cyc(12);
    chk(cmd.manual_mode, 1'b1);
    chk(po.operation_mode_indicator, 1'b1);
    chk(po.servo_ready_flag, 1'b1);
    chk(cmd.pause_hold, 1'b1);
    chk(po.emergency_stop_ok, 1'b0);
    chk(cmd.home_run, 1'b1);
    chk(po.homing_done_flag, 1'b1);
    pin.mode_select  <= 1'b0;
    pin.pause_n      <= 1'b1;
    pin.estop_closed <= 1'b1;
    pin.home_input   <= 1'b0;
    cyc(12);
    chk(po.operation_mode_indicator, 1'b0);
    chk(po.emergency_stop_ok, 1'b1);
    chk(cmd.home_run, 1'b0);
    $display("t_levels done");
  endtask

  task automatic t_start();
    pin.position_select_inputs <= 8'h2a;
    cyc(8);
    pin.program_start_input <= 1'b1;
    wait_start();
    chk(cmd.start_step, 8'h2a);
    cyc(2);
    chk(po.in_position_flag, 1'b0);
    settle();
    chk(po.arrived_position_outputs, 8'h2a);
    chk(po.in_position_flag, 1'b1);
    pin.program_start_input <= 1'b0;
    $display("t_start done");
  endtask

  // Level mode first, then edge mode with the input held
  task automatic t_direct();
    int n;
    logic s;
    s = 1'b0;
    pin.direct_move_inputs <= 7'b0010100;
    wait_start();
    chk(cmd.start_step, 8'h02);
    pin.direct_move_inputs <= 7'h00;
    settle();
    bus(1'b1, OFS_CTRL, 32'h1);
    pin.direct_move_inputs <= 7'b0000010;
    wait_start();
    chk(cmd.start_step, 8'h01);
    settle();
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      s = s | (cmd.start_req === 1'b1);
    end
    chk(s, 1'b0);
    pin.direct_move_inputs <= 7'h00;
    $display("t_direct done");
  endtask

  // Position rests at 1 after t_direct
  task automatic t_zone();
    bus(1'b0, OFS_INPOS_W, 32'h0);
    chk(rd, 32'(RST_INPOS_W));
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, OFS_ZONE_LO, 32'h2);
    cyc(4);
    chk(po.param_zone_flag, 1'b0);
    bus(1'b1, OFS_ZONE_LO, 32'h1);
    bus(1'b0, OFS_ZONE_LO, 32'h0);
    chk(rd, 32'h1);
    cyc(4);
    chk(po.param_zone_flag, 1'b1);
    chk(po.step_zone_flag, 1'b1);
    $display("t_zone done");
  endtask

  task automatic t_teach();
    int n;
    pin.teach_mode_input       <= 1'b1;
    pin.position_select_inputs <= 8'h05;
    pin.manual_move_plus       <= 1'b1;
    pin.manual_step_select     <= 1'b1;
    cyc(10);
    chk(po.teach_mode_indicator, 1'b1);
    chk(cmd.jog_plus, 1'b1);
    chk(cmd.inching, 1'b1);
    pin.teach_write_input <= 1'b1;
    for (n = 0; n < 200 && po.teach_write_done !== 1'b1; n++)
      @(posedge clk);
    lim(n, 200);
    chk(n, 32'd27);
    chk(cmd.teach_index, 8'h05);
    for (n = 0; n < 100 && po.teach_write_done === 1'b1; n++)
      @(posedge clk);
    chk(n, WD);
    pin.teach_write_input <= 1'b0;
    cyc(8);
    pin.teach_write_input <= 1'b1;
    for (n = 0; n < 200 && po.teach_write_done !== 1'b1; n++)
      @(posedge clk);
    lim(n, 200);
    pin.teach_mode_input <= 1'b0;
    cyc(8);
    chk(po.teach_write_done, 1'b0);
    chk(po.teach_mode_indicator, 1'b0);
    pin.teach_write_input <= 1'b0;
    $display("t_teach done");
  endtask

  task automatic t_alarm();
    alarm_in <= 1'b1;
    @(posedge clk);
    alarm_in <= 1'b0;
    cyc(4);
    chk(po.alarm_flag, 1'b1);
    pin.alarm_clear_input <= 1'b1;
    cyc(10);
    chk(po.alarm_flag, 1'b0);
    pin.alarm_clear_input <= 1'b0;
    $display("t_alarm done");
  endtask

  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    pin.pause_n      <= 1'b1;
    pin.estop_closed <= 1'b1;
    cyc(16);
    nrst <= 1'b1;
    t_levels();
    t_start();
    t_direct();
    t_zone();
    t_teach();
    t_alarm();
    stop_test();
  end
endmodule // test_turntable_controller_io
